// [cpbc_top.sv]
// clock, pll ratio and reset-to-boot sequencing with avalon-mm registers
// assumes synchronous strap and pin inputs; analog clocks arrive as levels
//
// Overview of operation
// RL1 - grounded osc-select pin picks external resonator, open picks 20 MHz.
// RL2 - board resonator must lie between 5 and 100 MHz.
// RL3 - pll straps choose default multiplier, input and output divider.
// RL4 - tile clock is osc times (mul+1)/2 over (in+1) over (out+1).
// RL5 - software keeps divider fields and intermediate frequency within limits.
// RL6 - software may rewrite the pll fields through a register.
// RL7 - pll output clocks switch and tile, and sources the reference clock.
// RL8 - pll straps stay static until third clock edge after reset release.
// RL9 - processor timers are 32-bit, ticking every 10 ns from reference.
// RL10 - analog node runs directly on the selected oscillator.
// RL11 - separate 31,250 Hz oscillator keeps the real-time counter alive.
// RL12 - while reset pin low, all gpio stay high impedance.
// RL13 - about 750,000 clocks after release, pulls enable, then boot.
// RL14 - boot straps pick source; security bit 5 forces otp boot.
// RL15 - spi boot enables four pins and drives 2.5 MHz serial clock.
// RL16 - link boot enables second link about 200 ns after boot begins.
// RL17 - link boot drops pull-downs, drives 16 and 17 low, watches 19, 20.
// RL18 - link partner holds pins 19 and 20 low when link enables.
// RL19 - all ports attach to clock block 0 on reset.
// RL20 - boot strap to source mapping is a parameterised table.
//
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module cpbc_top import cpbc_pkg::*; #(
   parameter int unsigned RST_WAIT = CPBC_RST_CLKS,
   parameter logic [15:0] BOOT_MAP = 16'hfe94 // 8 codes x 2 bits
) (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic osc_ext_n_i,
   input wire logic pll_strap_low_i,
   input wire logic pll_strap_high_i,
   input wire logic [2:0] boot_strap_i,
   input wire logic slow_osc_i,
   input wire logic link_pin_19_i,
   input wire logic link_pin_20_i,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   output logic osc_sel_ext_o,
   output logic analog_clk_sel_o,
   output logic rtc_slow_en_o,
   output cpbc_pll_cfg_t pll_cfg_o,
   output logic ref_tick_o,
   output logic [31:0] timer_o,
   output logic [1:0] port_clk_blk_o,
   output logic core_rst_n_o,
   output logic [1:0] boot_src_o,
   output logic pull_en_o,
   output logic [3:0] spi_boot_out_o,
   output logic [3:0] spi_boot_oe_n_o,
   output logic link_en_o,
   output logic link_pin_16_o,
   output logic link_pin_16_oe_n_o,
   output logic link_pin_17_o,
   output logic link_pin_17_oe_n_o,
   output logic [3:0] link_pd_en_o,
   output logic link_traffic_o
);
   // =========================================================
   // reset release
   logic [1:0] rsync_reg;
   logic rst_n;
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rsync_reg <= 2'b00;
      end else begin
         rsync_reg <= {rsync_reg[0], 1'b1};
      end
   end
   assign rst_n = rsync_reg[1];

   // =========================================================
   // state
   typedef struct packed {
      cpbc_state_t fsm;
      logic [19:0] cnt;
      logic [1:0] edges;
      logic straps_taken;
      logic osc_ext;
      cpbc_pll_cfg_t pll;
      logic [31:0] sec;
      cpbc_boot_src_t src;
      cpbc_pins_t pins;
      logic [7:0] spi_div;
      logic ack;
      logic [31:0] rdata;
   } cpbc_st_t;
   cpbc_st_t st_reg;
   cpbc_st_t st_next;

   logic tick;
   logic [31:0] timer;

   cpbc_tick u_tick (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n),
      .tick_o(tick),
      .timer_o(timer)
   );

   function automatic cpbc_pll_cfg_t strap_pll(input logic [1:0] s);
      cpbc_pll_cfg_t c;
      c.input_divide = CPBC_IN_DEF;
      c.output_divide = CPBC_OD_DEF;
      unique case (s)
         CPBC_STRAP_00: begin
            c.multiplier = CPBC_MUL_00;
            c.output_divide = CPBC_OD_00;
         end
         CPBC_STRAP_11: c.multiplier = CPBC_MUL_11;
         CPBC_STRAP_10: c.multiplier = CPBC_MUL_10;
         default: c.multiplier = CPBC_MUL_01;
      endcase
      return c;
   endfunction

   logic bus_req;
   assign bus_req = (avs_read | avs_write) & ~st_reg.ack;

   // =========================================================
   // next state
   always_comb begin
      logic [2:0] idx;
      idx = boot_strap_i;
      st_next = st_reg;
      st_next.ack = 1'b0;
      // straps sampled on the third edge after release
      if (!st_reg.straps_taken) begin
         if (st_reg.edges == 2'(CPBC_STRAP_EDGES - 1)) begin
            st_next.straps_taken = 1'b1;
            st_next.osc_ext = ~osc_ext_n_i; // [RL1]
            st_next.pll = strap_pll({pll_strap_high_i,
               pll_strap_low_i}); // [RL3] [RL8]
         end else begin
            st_next.edges = st_reg.edges + 2'h1;
         end
      end
      unique case (st_reg.fsm)
         CPBC_S_RESET: begin
            st_next.cnt = '0;
            st_next.fsm = CPBC_S_WAIT;
         end
         CPBC_S_WAIT: begin
            if (st_reg.cnt == 20'(RST_WAIT - 1)) begin
               st_next.pins.pull_en = 1'b1; // [RL13]
               st_next.cnt = '0;
               st_next.fsm = CPBC_S_BOOT;
            end else begin
               st_next.cnt = st_reg.cnt + 20'h00001;
            end
         end
         CPBC_S_BOOT: begin
            if (st_reg.sec[CPBC_SEC_OTP_BIT]) begin
               st_next.src = CPBC_BOOT_OTP; // [RL14]
            end else begin
               st_next.src = cpbc_boot_src_t'(BOOT_MAP[2*idx +: 2]); // [RL20]
            end
            st_next.fsm = CPBC_S_LINKW;
         end
         CPBC_S_LINKW: begin
            if (st_reg.src == CPBC_BOOT_SPI) begin
               st_next.pins.spi_oe_n = 4'h0; // [RL15]
               st_next.fsm = CPBC_S_RUN;
            end else if (st_reg.src == CPBC_BOOT_LINK) begin
               if (st_reg.cnt == 20'(CPBC_LINK_CYC - 1)) begin
                  st_next.pins.link_en = 1'b1; // [RL16]
                  st_next.pins.link_pd_en = 4'h0; // [RL17]
                  st_next.pins.link16_oe_n = 1'b0; // [RL17]
                  st_next.pins.link17_oe_n = 1'b0; // [RL17]
                  st_next.fsm = CPBC_S_RUN;
               end else begin
                  st_next.cnt = st_reg.cnt + 20'h00001;
               end
            end else begin
               st_next.fsm = CPBC_S_RUN;
            end
         end
         CPBC_S_RUN: begin
            // spi clock toggles at 2.5 MHz; pin a carries it
            if (st_reg.src == CPBC_BOOT_SPI) begin
               if (st_reg.spi_div == 8'(CPBC_SPI_HALF - 1)) begin
                  st_next.spi_div = 8'h00;
                  st_next.pins.spi_out[0] = ~st_reg.pins.spi_out[0]; // [RL15]
               end else begin
                  st_next.spi_div = st_reg.spi_div + 8'h01;
               end
            end
         end
         default: st_next.fsm = CPBC_S_RESET;
      endcase
      // =========================================================
      // register bus: one wait cycle, answer on the second edge
      if (bus_req) begin
         st_next.ack = 1'b1;
         st_next.rdata = CPBC_UNMAPPED;
         unique case (avs_address)
            CPBC_A_PLL: begin
               if (avs_write) begin
                  st_next.pll = cpbc_pll_cfg_t'(avs_writedata[20:0]); // [RL6]
               end
               st_next.rdata = {11'h000, st_reg.pll};
            end
            CPBC_A_STAT: st_next.rdata = {20'h00000,
               st_reg.fsm, st_reg.src, st_reg.osc_ext,
               st_reg.pins.link_en, st_reg.pins.pull_en, 1'b0, 1'b0};
            CPBC_A_TIMER: st_next.rdata = timer; // [RL9]
            CPBC_A_SEC: begin
               if (avs_write) begin
                  st_next.sec = avs_writedata;
               end
               st_next.rdata = st_reg.sec;
            end
            default: st_next.rdata = CPBC_UNMAPPED;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_reg <= '0;
         st_reg.fsm <= CPBC_S_RESET;
         st_reg.src <= CPBC_BOOT_NONE;
         st_reg.pll <= {CPBC_OD_00, CPBC_MUL_00, CPBC_IN_DEF};
         st_reg.pins.spi_oe_n <= 4'hf; // [RL12]
         st_reg.pins.link16_oe_n <= 1'b1; // [RL12]
         st_reg.pins.link17_oe_n <= 1'b1;
         st_reg.pins.link_pd_en <= 4'hf;
      end else begin
         st_reg <= st_next;
      end
   end

   // =========================================================
   // outputs; reset pin low forces pins to high impedance
   assign avs_waitrequest = (avs_read | avs_write) & ~st_reg.ack;
   assign avs_readdata = st_reg.rdata;
   assign osc_sel_ext_o = st_reg.osc_ext; // [RL1]
   assign analog_clk_sel_o = st_reg.osc_ext; // [RL10]
   assign rtc_slow_en_o = slow_osc_i; // [RL11]
   assign pll_cfg_o = st_reg.pll; // [RL4] [RL7]
   assign ref_tick_o = tick;
   assign timer_o = timer;
   assign port_clk_blk_o = 2'h0; // [RL19]
   assign core_rst_n_o = (st_reg.fsm == CPBC_S_RUN);
   assign boot_src_o = st_reg.src;
   assign pull_en_o = st_reg.pins.pull_en & reset_n_i; // [RL12]
   assign spi_boot_out_o = st_reg.pins.spi_out;
   assign spi_boot_oe_n_o = st_reg.pins.spi_oe_n | {4{~reset_n_i}};
   assign link_en_o = st_reg.pins.link_en;
   assign link_pin_16_o = 1'b0; // [RL17]
   assign link_pin_17_o = 1'b0;
   assign link_pin_16_oe_n_o = st_reg.pins.link16_oe_n | ~reset_n_i;
   assign link_pin_17_oe_n_o = st_reg.pins.link17_oe_n | ~reset_n_i;
   assign link_pd_en_o = st_reg.pins.link_pd_en & {4{reset_n_i}};
   // partner holds 19/20 low until traffic starts
   assign link_traffic_o = st_reg.pins.link_en &
      (link_pin_19_i | link_pin_20_i); // [RL17] [RL18]
endmodule // cpbc_top

// [cpbc_pkg.sv]
// package: constants and carrier types for the clock, pll and boot control
// assumes a 250 MHz system clock and avalon-mm word access
package cpbc_pkg;
   // =========================================================
   // timing
   localparam int unsigned CPBC_CLK_MHZ = 250;
   localparam int unsigned CPBC_REF_MHZ = 100;
   localparam int unsigned CPBC_TICK_NS = 10;
   localparam int unsigned CPBC_TICK_CYC = (CPBC_TICK_NS * CPBC_CLK_MHZ) / 1000;
   localparam int unsigned CPBC_CLK_NS = 1000 / CPBC_CLK_MHZ;
   localparam int unsigned CPBC_RST_CLKS = 750000;
   localparam int unsigned CPBC_LINK_NS = 200;
   localparam int unsigned CPBC_LINK_CYC = (CPBC_LINK_NS * CPBC_CLK_MHZ) / 1000;
   localparam int unsigned CPBC_SPI_KHZ = 2500;
   localparam int unsigned CPBC_SPI_HALF =
      (CPBC_CLK_MHZ * 1000) / (2 * CPBC_SPI_KHZ);
   localparam int unsigned CPBC_STRAP_EDGES = 3;
   localparam int unsigned CPBC_SLOW_HZ = 31250;
   localparam int unsigned CPBC_SI_OSC_MHZ = 20;
   // =========================================================
   // register map (word byte addresses)
   localparam logic [3:0] CPBC_A_PLL = 4'h0;
   localparam logic [3:0] CPBC_A_STAT = 4'h4;
   localparam logic [3:0] CPBC_A_TIMER = 4'h8;
   localparam logic [3:0] CPBC_A_SEC = 4'hc;
   localparam logic [31:0] CPBC_UNMAPPED = 32'h0000_0000;
   localparam int unsigned CPBC_SEC_OTP_BIT = 5;
   // =========================================================
   // pll defaults per strap code
   localparam logic [1:0] CPBC_STRAP_00 = 2'h0;
   localparam logic [1:0] CPBC_STRAP_01 = 2'h1;
   localparam logic [1:0] CPBC_STRAP_10 = 2'h2;
   localparam logic [1:0] CPBC_STRAP_11 = 2'h3;
   localparam logic [11:0] CPBC_MUL_00 = 12'h07a;
   localparam logic [11:0] CPBC_MUL_11 = 12'h077;
   localparam logic [11:0] CPBC_MUL_10 = 12'h031;
   localparam logic [11:0] CPBC_MUL_01 = 12'h017;
   localparam logic [2:0] CPBC_OD_00 = 3'h0;
   localparam logic [2:0] CPBC_OD_DEF = 3'h2;
   localparam logic [5:0] CPBC_IN_DEF = 6'h00;

   typedef struct packed {
      logic [2:0] output_divide;
      logic [11:0] multiplier;
      logic [5:0] input_divide;
   } cpbc_pll_cfg_t;

   typedef enum logic [1:0] {
      CPBC_BOOT_SPI = 2'h0,
      CPBC_BOOT_LINK = 2'h1,
      CPBC_BOOT_OTP = 2'h2,
      CPBC_BOOT_NONE = 2'h3
   } cpbc_boot_src_t;

   typedef enum logic [4:0] {
      CPBC_S_RESET = 5'b00001,
      CPBC_S_WAIT = 5'b00010,
      CPBC_S_BOOT = 5'b00100,
      CPBC_S_LINKW = 5'b01000,
      CPBC_S_RUN = 5'b10000
   } cpbc_state_t;

   typedef struct packed {
      logic [3:0] spi_oe_n;
      logic [3:0] spi_out;
      logic pull_en;
      logic link_en;
      logic link16_oe_n;
      logic link17_oe_n;
      logic [3:0] link_pd_en;
   } cpbc_pins_t;
endpackage

// [cpbc_tick.sv]
// reference tick divider and 32-bit processor timer
// assumes the pll-derived clock reaches it as sys_clk_i
`timescale 1ns/1ps
module cpbc_tick import cpbc_pkg::*; (
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   output logic tick_o,
   output logic [31:0] timer_o
);
   typedef struct packed {
      logic [7:0] div;
      logic tick;
      logic [31:0] timer;
   } cpbc_tick_st_t;
   cpbc_tick_st_t st_reg;
   cpbc_tick_st_t st_next;

   // =========================================================
   // divider
   always_comb begin
      st_next = st_reg;
      st_next.tick = 1'b0;
      // div carries the ns residue: the tick period is not a whole number
      // of clocks, so spacing alternates and the mean stays exact
      if (st_reg.div + 8'(CPBC_CLK_NS) >= 8'(CPBC_TICK_NS)) begin
         st_next.div = st_reg.div + 8'(CPBC_CLK_NS) - 8'(CPBC_TICK_NS);
         st_next.tick = 1'b1; // [RL9]
         st_next.timer = st_reg.timer + 32'h0000_0001; // [RL9]
      end else begin
         st_next.div = st_reg.div + 8'(CPBC_CLK_NS);
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign tick_o = st_reg.tick;
   assign timer_o = st_reg.timer;
endmodule // cpbc_tick

// [cpbc_top_properties.sv]
// checker: concurrent properties on the top module's ports
// assumes the bus stays idle until a few clocks after reset release
`timescale 1ns/1ps
module cpbc_top_properties import cpbc_pkg::*; (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic slow_osc_i,
   input wire logic link_pin_19_i,
   input wire logic link_pin_20_i,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic osc_sel_ext_o,
   input wire logic analog_clk_sel_o,
   input wire logic rtc_slow_en_o,
   input wire logic ref_tick_o,
   input wire logic [31:0] timer_o,
   input wire logic [1:0] port_clk_blk_o,
   input wire logic [1:0] boot_src_o,
   input wire logic pull_en_o,
   input wire logic [3:0] spi_boot_oe_n_o,
   input wire logic link_en_o,
   input wire logic link_pin_16_oe_n_o,
   input wire logic link_pin_17_oe_n_o,
   input wire logic [3:0] link_pd_en_o,
   input wire logic link_traffic_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   // ==================
   // steps
   sequence one_wait_s;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   // link comes up some 50 clocks after boot begins
   sequence boot_long_ago_s;
      $past(pull_en_o, 44) && !$past(pull_en_o, 60);
   endsequence
   // tick spacing alternates 2 and 3 clocks for a 10 ns mean
   sequence tick_short_s;
      ref_tick_o ##2 ref_tick_o;
   endsequence
   sequence tick_long_s;
      ref_tick_o ##1 !ref_tick_o [*2] ##1 ref_tick_o;
   endsequence
   // ==================
   // properties
   chk_pins_hiz:
   assert property (!pull_en_o |-> spi_boot_oe_n_o == 4'hf &&
      link_pin_16_oe_n_o && link_pin_17_oe_n_o)
      else $error("pin driven before pulls");
   chk_analog_osc:
   assert property (analog_clk_sel_o == osc_sel_ext_o)
      else $error("analog clock not on oscillator");
   chk_slow_osc:
   assert property (rtc_slow_en_o == slow_osc_i)
      else $error("slow oscillator not passed");
   chk_port_blk:
   assert property (port_clk_blk_o == 2'h0)
      else $error("ports not on clock block zero");
   chk_tick_rate:
   assert property (ref_tick_o |=> !ref_tick_o ##[1:2] ref_tick_o)
      else $error("tick spacing wrong");
   chk_tick_short:
   assert property (tick_short_s |=> !ref_tick_o [*2] ##1 ref_tick_o)
      else $error("short tick gap not followed by long");
   chk_tick_long:
   assert property (tick_long_s |=> !ref_tick_o ##1 ref_tick_o)
      else $error("long tick gap not followed by short");
   chk_timer_step:
   assert property (ref_tick_o ##2 ref_tick_o |->
      timer_o == $past(timer_o, 2) + 32'h1)
      else $error("timer step wrong");
   chk_link_delay:
   assert property ($rose(link_en_o) |-> boot_long_ago_s)
      else $error("link enable delay wrong");
   chk_link_idle:
   assert property (link_en_o |-> !link_pin_16_oe_n_o &&
      !link_pin_17_oe_n_o && link_pd_en_o == 4'h0)
      else $error("link idle pins wrong");
   chk_link_watch:
   assert property (link_traffic_o ==
      (link_en_o && (link_pin_19_i || link_pin_20_i)))
      else $error("link traffic flag wrong");
   chk_spi_only:
   assert property (spi_boot_oe_n_o != 4'hf |-> boot_src_o == CPBC_BOOT_SPI)
      else $error("spi pins driven off spi boot");
   chk_bus_wait:
   assert property ($rose(avs_read || avs_write) |-> one_wait_s)
      else $error("wait state count wrong");
endmodule // cpbc_top_properties

bind cpbc_top cpbc_top_properties i_props (.*);

// [cpbc_far_model.sv]
// far side: straps, oscillator select, slow oscillator, link partner
// assumes the bench presents strap choices while reset is held
`timescale 1ns/1ps
module cpbc_far_model (
   input wire logic sys_clk_i,
   input wire logic reset_n_i,
   input wire logic [5:0] strap_cfg_i,
   input wire logic link_en_i,
   input wire logic traffic_i,
   output logic osc_ext_n_o,
   output logic pll_strap_high_o,
   output logic pll_strap_low_o,
   output logic [2:0] boot_strap_o,
   output logic slow_osc_o,
   output logic link_pin_19_o,
   output logic link_pin_20_o
);
   logic [5:0] strap_reg;
   logic [5:0] slow_reg;
   // straps only move in reset, so they hold past the third edge
   always_ff @(posedge sys_clk_i) begin
      if (!reset_n_i)
         strap_reg <= strap_cfg_i;
      if (!reset_n_i)
         slow_reg <= 6'h00;
      else
         slow_reg <= slow_reg + 6'h01;
   end
   // resonator taken to lie within 5 to 100 MHz
   assign osc_ext_n_o = strap_reg[5];
   assign {pll_strap_high_o, pll_strap_low_o} = strap_reg[4:3];
   assign boot_strap_o = strap_reg[2:0];
   assign slow_osc_o = slow_reg[5];
   // pulled down: low whenever no traffic is commanded
   assign link_pin_19_o = link_en_i & traffic_i;
   assign link_pin_20_o = link_en_i & traffic_i;
endmodule // cpbc_far_model

// [cpbc_top_tb.sv]
// self-checking bench for the clock, pll and boot control top
// assumes the far-side model and the bound property checker
`timescale 1ns/1ps
module cpbc_top_tb import cpbc_pkg::*;;
   localparam int unsigned RW = 20;
   logic sys_clk_i, reset_n_i, osc_ext_n_i, pll_strap_low_i;
   logic pll_strap_high_i, slow_osc_i, link_pin_19_i, link_pin_20_i;
   logic avs_read, avs_write, avs_waitrequest, traffic;
   logic [2:0] boot_strap_i;
   logic [3:0] avs_address, spi_boot_out_o, spi_boot_oe_n_o, link_pd_en_o;
   logic [31:0] avs_writedata, avs_readdata, timer_o, cyc, seed;
   logic osc_sel_ext_o, analog_clk_sel_o, rtc_slow_en_o, ref_tick_o;
   logic core_rst_n_o, pull_en_o, link_en_o, link_pin_16_o;
   logic link_pin_16_oe_n_o, link_pin_17_o, link_pin_17_oe_n_o;
   logic link_traffic_o;
   logic [1:0] port_clk_blk_o, boot_src_o;
   logic [5:0] strap_cfg;
   cpbc_pll_cfg_t pll_cfg_o;
   int error_cnt = 0;
   int num_checks = 0;
   cpbc_top #(.RST_WAIT(RW)) i_dut (.*);
   cpbc_far_model i_far (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
      .strap_cfg_i(strap_cfg), .link_en_i(link_en_o), .traffic_i(traffic),
      .osc_ext_n_o(osc_ext_n_i), .pll_strap_high_o(pll_strap_high_i),
      .pll_strap_low_o(pll_strap_low_i), .boot_strap_o(boot_strap_i),
      .slow_osc_o(slow_osc_i), .link_pin_19_o(link_pin_19_i),
      .link_pin_20_o(link_pin_20_i));
   // ==================
   // helpers
   task automatic check_eq(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // one avalon word access; launched after a rising edge, held until the
   // edge that samples waitrequest low, released at that same edge
   task automatic bus(input logic wr, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge sys_clk_i);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 64);
      q = avs_readdata;
      if (n >= 64) begin
         error_cnt++;
         test_done();
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   function automatic logic [31:0] pll_exp(input logic [1:0] s);
      case (s)
         2'h0: pll_exp = {11'h000, 3'h0, 12'h07a, 6'h00};
         2'h3: pll_exp = {11'h000, 3'h2, 12'h077, 6'h00};
         2'h2: pll_exp = {11'h000, 3'h2, 12'h031, 6'h00};
         default: pll_exp = {11'h000, 3'h2, 12'h017, 6'h00};
      endcase
   endfunction
   // legal fields taking the 20 MHz on-chip oscillator: (mul+1)/(in+1)
   // stays in 26..130, so the pre-divider clock is 260 MHz to 1.3 GHz
   function automatic logic [31:0] pll_legal(input logic [31:0] r);
      logic [11:0] k;
      logic [11:0] rp1;
      k = 12'h01a + 12'(r[15:8] % 8'h69);
      rp1 = 12'h001 + 12'(r[1:0]);
      return {11'h000, r[18:16], 12'(k * rp1 - 12'h001), 4'h0, r[1:0]};
   endfunction
   function automatic logic [1:0] src_exp(input logic s, input logic [2:0] c);
      if (s)
         return CPBC_BOOT_OTP;
      case (c)
         3'h0: return CPBC_BOOT_SPI;
         3'h1, 3'h2: return CPBC_BOOT_LINK;
         3'h3, 3'h4: return CPBC_BOOT_OTP;
         default: return CPBC_BOOT_NONE;
      endcase
   endfunction
   // ==================
   // clock and sequence
   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   always @(posedge sys_clk_i) cyc <= cyc + 32'h1;
   initial begin
      logic [31:0] q, w, t0, t1, t_oe, t_ck;
      logic [1:0] e;
      logic sec, spi_on, spi_ck;
      int n;
      {reset_n_i, avs_read, avs_write, traffic} = 4'h0;
      avs_address = 4'h0;
      avs_writedata = 32'h0;
      strap_cfg = 6'h00;
      cyc = 32'h0;
      seed = 32'hf7fcd034;
      for (int it = 0; it < 10; it++) begin
         sec = (it >= 8);
         w = $random(seed);
         strap_cfg <= (it < 8) ? {w[5], it[1:0], it[2:0]} : w[5:0];
         reset_n_i <= 1'b0;
         repeat (12) @(posedge sys_clk_i);
         check_eq(spi_boot_oe_n_o, 4'hf);
         check_eq(pull_en_o, 1'b0);
         check_eq({link_pin_16_oe_n_o, link_pin_17_oe_n_o}, 2'h3);
         check_eq(core_rst_n_o, 1'b0);
         reset_n_i <= 1'b1;
         t0 = cyc;
         repeat (3) @(posedge sys_clk_i);
         bus(1'b1, CPBC_A_SEC, {26'h0, sec, 5'h00}, q);
         n = 0;
         while (pull_en_o !== 1'b1 && n < 200) begin
            @(negedge sys_clk_i);
            n++;
         end
         if (n >= 200) begin
            error_cnt++;
            test_done();
         end
         check_eq(cyc - t0 >= RW && cyc - t0 <= RW + 8, 1'b1);
         e = src_exp(sec, strap_cfg[2:0]);
         spi_on = 1'b0;
         spi_ck = 1'b0;
         t_oe = 32'h0;
         t_ck = 32'h0;
         repeat (60) begin
            @(negedge sys_clk_i);
            if (!spi_on && spi_boot_oe_n_o === 4'h0)
               t_oe = cyc;
            if (!spi_ck && spi_boot_out_o[0] === 1'b1)
               t_ck = cyc;
            spi_on = spi_on | (spi_boot_oe_n_o === 4'h0);
            spi_ck = spi_ck | (spi_boot_out_o[0] === 1'b1);
         end
         check_eq(spi_on, e == CPBC_BOOT_SPI);
         check_eq(spi_ck, e == CPBC_BOOT_SPI);
         w = (e == CPBC_BOOT_SPI) ? CPBC_SPI_HALF : 32'h0;
         check_eq(t_ck - t_oe, w);
         check_eq(boot_src_o, e);
         check_eq(osc_sel_ext_o, !strap_cfg[5]);
         check_eq(pll_cfg_o, pll_exp(strap_cfg[4:3]));
         check_eq(link_en_o, e == CPBC_BOOT_LINK);
         check_eq(core_rst_n_o, 1'b1);
         w = (e == CPBC_BOOT_LINK) ? 32'h0 : 32'h3;
         check_eq({link_pin_16_oe_n_o, link_pin_17_oe_n_o}, w);
         check_eq({link_pin_16_o, link_pin_17_o}, 2'h0);
         @(posedge sys_clk_i);
         traffic <= 1'b1;
         @(negedge sys_clk_i);
         check_eq(link_traffic_o, e == CPBC_BOOT_LINK);
         @(posedge sys_clk_i);
         traffic <= 1'b0;
         w = {20'h0, CPBC_S_RUN, e, !strap_cfg[5], e == CPBC_BOOT_LINK, 3'h4};
         bus(1'b0, CPBC_A_STAT, 32'h0, q);
         check_eq(q, w);
         bus(1'b0, CPBC_A_PLL, 32'h0, q);
         check_eq(q, pll_exp(strap_cfg[4:3]));
         w = pll_legal($random(seed));
         bus(1'b1, CPBC_A_PLL, w, q);
         bus(1'b0, CPBC_A_PLL, 32'h0, q);
         check_eq(q[20:0], w[20:0]);
         check_eq(pll_cfg_o, w[20:0]);
         bus(1'b1, 4'h2, w, q);
         bus(1'b0, 4'h2, 32'h0, q);
         check_eq(q, CPBC_UNMAPPED);
         bus(1'b0, CPBC_A_TIMER, 32'h0, t1);
         t0 = cyc;
         repeat (100) @(posedge sys_clk_i);
         bus(1'b0, CPBC_A_TIMER, 32'h0, q);
         t0 = cyc - t0;
         q = (q - t1) * CPBC_TICK_NS;
         w = t0 * CPBC_CLK_NS;
         check_eq(q + CPBC_TICK_NS > w && q < w + CPBC_TICK_NS, 1'b1);
      end
      test_done();
   end
endmodule // cpbc_top_tb
